//--- inc/debug_port_consts.svh
// Constants for the debug scan and program-counter trace port
`ifndef DEBUG_PORT_CONSTS_SVH
`define DEBUG_PORT_CONSTS_SVH
`define IR_W 4
`define IR_IDCODE 4'h1
`define IR_TRACE 4'h8
`define IR_BYPASS 4'hf
`define IR_RESET_VALUE 4'h1
`define IR_CAPTURE_VALUE 4'h1
`define DR_W 32
`define PC_W 32
`define NIBBLE_W 4
`define STATUS_W 9
`define STATUS_RESET 9'h000
`define UPPER_RESET 3'h7
`define DEBUG_CLK_DIV 3
`define TRACE_FIFO_DEPTH 8
`endif

//--- inc/debug_port_pkg.sv
// Types shared by the debug port design files
package debug_port_pkg;
  `include "debug_port_consts.svh"

  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SHIFT_DR = 16'h0010, TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040, TAP_EXIT2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000, TAP_PAUSE_IR = 16'h2000, TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } tap_state_type;

  typedef struct packed {
    logic [`STATUS_W-1:0] status;
    logic [`PC_W-1:0] pc;
  } trace_word_type;
endpackage : debug_port_pkg

//--- rtl/debug_clk_div.sv
// Core clock divider making the debug clock and its update enable
`timescale 1ns/1ns
`include "debug_port_consts.svh"
module debug_clk_div #(
  parameter int DIV = `DEBUG_CLK_DIV
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Divided clock and enable
  output logic debug_clock_out,
  output logic tick_out
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;

  assign cnt_nxt = (cnt_r == 2'(DIV - 1)) ? 2'h0 : cnt_r + 2'h1;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Rising debug clock and tick share one core cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      debug_clock_out <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      debug_clock_out <= (cnt_nxt == 2'h0); // see RULE6
      tick_out <= (cnt_nxt == 2'h0);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_div_period;
    @(posedge clk_in) disable iff (!rst_n_in)
      tick_out |=> !tick_out ##1 !tick_out ##1 tick_out;
  endproperty
  a_div_period: assert property (p_div_period) else $error("debug clock not core/3"); // see RULE6
endmodule : debug_clk_div

//--- rtl/debug_port.sv
// Debug scan access port and program-counter trace output
//
// Overview of operation
// RULE1: Trace off: serial input pin shifts into selected instruction or data register.
// RULE2: Trace on: serial input pin is low-active interrupt that cancels trace.
// RULE3: Trace off: serial output pin carries data shifted out of the port.
// RULE4: Trace on: serial output pin carries PC nibble bit zero on debug clock.
// RULE5: Three upper trace pins carry remaining PC nibble bits on debug clock.
// RULE6: Debug clock is the core clock divided by three.
// RULE7: Trace pins and status bus change only with the debug clock.
// RULE8: Test reset low clears port state machine and trace unit at once; the trace FIFO is only flushed later, through the trst_s2 synchroniser.
// RULE9: Test reset high disables internal bus timeout detection.
// RULE10: Port state machine steps by TMS level sampled on test clock.
// RULE11: Test clock times instructions and serial shifting.
// RULE12: Nine-bit status bus shows trace status, all low after reset.
// RULE13: Sixteen-state sequence; capture on rising, output change on falling test clock.
`timescale 1ns/1ns
`include "debug_port_consts.svh"
module debug_port #(
  parameter logic [31:0] IDCODE_VALUE = 32'h00000001, // Arbitrary value
  parameter int FIFO_DEPTH = `TRACE_FIFO_DEPTH
) (
  // Core clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Scan pins
  input wire logic test_clock_in,
  input wire logic test_mode_sel_in,
  input wire logic test_reset_n_in,
  input wire logic serial_in_or_debug_irq_in,
  output logic serial_out_or_trace_bit0_out,
  // Trace pins
  output logic [2:0] trace_pc_upper_bits_out,
  output logic [`STATUS_W-1:0] trace_status_bus_out,
  output logic debug_clock_out,
  // Core side trace stream
  input wire debug_port_pkg::trace_word_type trace_word_in,
  input wire logic trace_valid_in,
  output logic trace_ready_out,
  output logic trace_mode_out,
  // System bus control
  output logic bus_timeout_disable_out
);
  import debug_port_pkg::*;

  localparam int BEATS = `PC_W / `NIBBLE_W;
  localparam int BW = $clog2(BEATS);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic tck_s1, tck_s2, tck_s3;
  logic tms_s1, tms_s2;
  logic tdi_s1, tdi_s2;
  logic trst_s1, trst_s2;
  logic tck_rise, tck_fall;

  always_ff @(posedge clk_in) begin
    tck_s1 <= test_clock_in;
    tck_s2 <= tck_s1;
    tck_s3 <= tck_s2;
    tms_s1 <= test_mode_sel_in;
    tms_s2 <= tms_s1;
    tdi_s1 <= serial_in_or_debug_irq_in;
    tdi_s2 <= tdi_s1;
    trst_s1 <= test_reset_n_in;
    trst_s2 <= trst_s1;
  end

  assign tck_rise = tck_s2 && !tck_s3; // see RULE11
  assign tck_fall = !tck_s2 && tck_s3;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_timeout_disable_out <= 1'b0;
    end else begin
      bus_timeout_disable_out <= trst_s2; // see RULE9
    end
  end

  // ----------------------------------------
  // Port state machine
  // ----------------------------------------
  tap_state_type state_r, state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TAP_RESET: state_nxt = tms_s2 ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: state_nxt = tms_s2 ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: state_nxt = tms_s2 ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_nxt = tms_s2 ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: state_nxt = tms_s2 ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: state_nxt = tms_s2 ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: state_nxt = tms_s2 ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: state_nxt = tms_s2 ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: state_nxt = tms_s2 ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: state_nxt = tms_s2 ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: state_nxt = tms_s2 ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: state_nxt = tms_s2 ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: state_nxt = tms_s2 ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: state_nxt = tms_s2 ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: state_nxt = tms_s2 ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: state_nxt = tms_s2 ? TAP_SEL_DR : TAP_IDLE;
      default: state_nxt = TAP_RESET;
    endcase
  end

  always_ff @(posedge clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      state_r <= TAP_RESET; // see RULE8
    end else if (!rst_n_in) begin
      state_r <= TAP_RESET;
    end else if (tck_rise) begin
      state_r <= state_nxt; // see RULE10, RULE13
    end
  end

  // ----------------------------------------
  // Instruction and data registers
  // ----------------------------------------
  logic [`IR_W-1:0] ir_shift_r, ir_r;
  logic [`DR_W-1:0] dr_shift_r;
  logic trace_mode_r;
  logic tdo_r;

  always_ff @(posedge clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      ir_shift_r <= `IR_RESET_VALUE;
      ir_r <= `IR_RESET_VALUE;
    end else if (!rst_n_in) begin
      ir_shift_r <= `IR_RESET_VALUE;
      ir_r <= `IR_RESET_VALUE;
    end else if (tck_rise) begin
      if (state_r == TAP_RESET) begin
        ir_r <= `IR_RESET_VALUE;
      end else if (state_r == TAP_CAP_IR) begin
        ir_shift_r <= `IR_CAPTURE_VALUE;
      end else if (state_r == TAP_SHIFT_IR && !trace_mode_r) begin
        ir_shift_r <= {tdi_s2, ir_shift_r[`IR_W-1:1]}; // see RULE1
      end else if (state_r == TAP_UPD_IR) begin
        ir_r <= ir_shift_r;
      end
    end
  end

  always_ff @(posedge clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      dr_shift_r <= '0;
    end else if (!rst_n_in) begin
      dr_shift_r <= '0;
    end else if (tck_rise) begin
      if (state_r == TAP_CAP_DR) begin
        if (ir_r == `IR_IDCODE) begin
          dr_shift_r <= IDCODE_VALUE;
        end else if (ir_r == `IR_TRACE) begin
          dr_shift_r <= {31'h0, trace_mode_r};
        end else begin
          dr_shift_r <= '0;
        end
      end else if (state_r == TAP_SHIFT_DR && !trace_mode_r) begin
        if (ir_r == `IR_IDCODE) begin
          dr_shift_r <= {tdi_s2, dr_shift_r[`DR_W-1:1]}; // see RULE1
        end else begin
          dr_shift_r <= {31'h0, tdi_s2}; // see RULE1
        end
      end
    end
  end

  // Serial output moves only on falling test clock
  always_ff @(posedge clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      tdo_r <= 1'b0;
    end else if (!rst_n_in) begin
      tdo_r <= 1'b0;
    end else if (tck_fall) begin
      if (state_r == TAP_SHIFT_IR) begin
        tdo_r <= ir_shift_r[0]; // see RULE13
      end else if (state_r == TAP_SHIFT_DR) begin
        tdo_r <= dr_shift_r[0]; // see RULE13
      end
    end
  end

  // Trace mode: set by update of trace register, cleared by low interrupt pin
  always_ff @(posedge clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      trace_mode_r <= 1'b0; // see RULE8
    end else if (!rst_n_in) begin
      trace_mode_r <= 1'b0;
    end else if (tck_rise && state_r == TAP_UPD_DR && ir_r == `IR_TRACE) begin
      trace_mode_r <= dr_shift_r[0];
    end else if (trace_mode_r && !tdi_s2) begin
      trace_mode_r <= 1'b0; // see RULE2
    end
  end

  assign trace_mode_out = trace_mode_r;

  // ----------------------------------------
  // Debug clock and trace buffer
  // ----------------------------------------
  logic dbg_tick;
  trace_word_type fifo_word;
  logic fifo_valid, fifo_ready;

  debug_clk_div #(
    .DIV(`DEBUG_CLK_DIV)
  ) u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .debug_clock_out(debug_clock_out), // see RULE6
    .tick_out(dbg_tick)
  );

  trace_fifo #(
    .WIDTH($bits(trace_word_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .flush_in(!trst_s2),
    .in_data_in(trace_word_in),
    .in_valid_in(trace_valid_in),
    .in_ready_out(trace_ready_out),
    .out_data_out(fifo_word),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_ready)
  );

  // ----------------------------------------
  // Trace output engine
  // ----------------------------------------
  logic busy_r;
  logic [BW-1:0] beat_r;
  logic [`PC_W-1:0] pc_shift_r;
  logic bit0_r;
  logic last_beat;

  assign last_beat = (beat_r == BW'(BEATS - 1));
  // Outside trace mode stale words are dropped, not held for later
  assign fifo_ready = trace_mode_r ? (dbg_tick && (!busy_r || last_beat)) : 1'b1;

  always_ff @(posedge clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      busy_r <= 1'b0;
      beat_r <= '0;
      pc_shift_r <= '0;
      bit0_r <= 1'b0;
      trace_pc_upper_bits_out <= `UPPER_RESET;
      trace_status_bus_out <= `STATUS_RESET; // see RULE8
    end else if (!rst_n_in) begin
      busy_r <= 1'b0;
      beat_r <= '0;
      pc_shift_r <= '0;
      bit0_r <= 1'b0;
      trace_pc_upper_bits_out <= `UPPER_RESET;
      trace_status_bus_out <= `STATUS_RESET; // see RULE12
    end else if (dbg_tick) begin
      if (busy_r && !last_beat) begin
        {trace_pc_upper_bits_out, bit0_r} <= pc_shift_r[3:0]; // see RULE5, RULE7
        pc_shift_r <= pc_shift_r >> `NIBBLE_W;
        beat_r <= beat_r + 1'b1;
        trace_status_bus_out <= `STATUS_RESET;
      end else if (trace_mode_r && fifo_valid) begin
        {trace_pc_upper_bits_out, bit0_r} <= fifo_word.pc[3:0]; // see RULE5, RULE7
        pc_shift_r <= fifo_word.pc >> `NIBBLE_W;
        beat_r <= '0;
        busy_r <= 1'b1;
        trace_status_bus_out <= fifo_word.status; // see RULE12
      end else begin
        busy_r <= 1'b0;
        trace_status_bus_out <= `STATUS_RESET;
      end
    end
  end

  assign serial_out_or_trace_bit0_out = trace_mode_r ? bit0_r : tdo_r; // see RULE3, RULE4

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in || !test_reset_n_in);

  property p_tdi_shift;
    tck_rise && state_r == TAP_SHIFT_DR && !trace_mode_r && ir_r == `IR_BYPASS
      |=> dr_shift_r[0] == $past(tdi_s2);
  endproperty
  a_tdi_shift: assert property (p_tdi_shift) else $error("serial input not shifted"); // see RULE1

  property p_irq_cancel;
    trace_mode_r && !tdi_s2 && !(tck_rise && state_r == TAP_UPD_DR) |=> !trace_mode_r;
  endproperty
  a_irq_cancel: assert property (p_irq_cancel) else $error("trace not cancelled"); // see RULE2

  property p_tdo_mux;
    !trace_mode_r |-> serial_out_or_trace_bit0_out == tdo_r;
  endproperty
  a_tdo_mux: assert property (p_tdo_mux) else $error("scan output wrong"); // see RULE3

  property p_trace_bit0;
    dbg_tick && trace_mode_r && fifo_valid && !busy_r && trst_s2
      |=> trace_mode_r |-> serial_out_or_trace_bit0_out == $past(fifo_word.pc[0]);
  endproperty
  a_trace_bit0: assert property (p_trace_bit0) else $error("trace bit0 wrong"); // see RULE4

  property p_trace_sync;
    !dbg_tick |=> $stable(trace_pc_upper_bits_out) && $stable(trace_status_bus_out);
  endproperty
  a_trace_sync: assert property (p_trace_sync) else $error("trace moved off tick"); // see RULE7

  property p_timeout_off;
    $rose(trst_s2) |=> bus_timeout_disable_out;
  endproperty
  a_timeout_off: assert property (p_timeout_off) else $error("timeout not disabled"); // see RULE9

  property p_tms_step;
    tck_rise && state_r == TAP_RESET && !tms_s2 |=> state_r == TAP_IDLE;
  endproperty
  a_tms_step: assert property (p_tms_step) else $error("state machine step wrong"); // see RULE10

  property p_tck_only;
    !tck_rise |=> $stable(state_r) && $stable(ir_r);
  endproperty
  a_tck_only: assert property (p_tck_only) else $error("state moved without test clock"); // see RULE11

  property p_status_reset;
    $rose(rst_n_in) |-> trace_status_bus_out == `STATUS_RESET;
  endproperty
  a_status_reset: assert property (@(posedge clk_in) p_status_reset) else $error("status not low"); // see RULE12

  property p_tdo_fall;
    !tck_fall |=> $stable(tdo_r);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("scan output off falling edge"); // see RULE13

  c_trace_on: cover property (!trace_mode_r ##1 trace_mode_r);
  c_trace_word: cover property (fifo_ready && fifo_valid && trace_mode_r);
  c_fifo_full: cover property (trace_valid_in && !trace_ready_out);
  c_idcode_shift: cover property (state_r == TAP_SHIFT_DR && ir_r == `IR_IDCODE);
endmodule : debug_port

//--- rtl/trace_fifo.sv
// Synchronous FIFO holding trace words ahead of the pins
`timescale 1ns/1ns
module trace_fifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  // Fill side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready_out = (count_r != (AW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign push = in_valid_in && in_ready_out && !flush_in;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem_r[rd_r];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || flush_in) begin
      wr_r <= '0;
      rd_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : trace_fifo

//--- testbench/debug_probe.sv
// Debug probe model: scan pin driver and trace nibble capture
`timescale 1ns/1ns
module debug_probe (
  // Core clock
  input wire logic clk_in,
  // Scan pins
  output logic test_clock_out,
  output logic test_mode_sel_out,
  output logic serial_in_or_debug_irq_out,
  input wire logic serial_out_or_trace_bit0_in,
  // Trace pins
  input wire logic [2:0] trace_pc_upper_bits_in,
  input wire logic [8:0] trace_status_bus_in,
  input wire logic debug_clock_in
);
  logic cap_en_r;
  logic [12:0] cap_q[$];

  // Test clock rests low between frames, data line at its pull-up level
  initial begin
    test_clock_out = 1'b0;
    test_mode_sel_out = 1'b1;
    serial_in_or_debug_irq_out = 1'b1;
    cap_en_r = 1'b0;
  end

  // Trace pins are taken at the debug clock rise
  always @(posedge debug_clock_in) begin
    if (cap_en_r) begin
      cap_q.push_back({trace_status_bus_in, trace_pc_upper_bits_in,
                       serial_out_or_trace_bit0_in});
    end
  end

  // One test clock period, five core cycles per half; output read before the rise
  task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo);
    test_mode_sel_out <= tms;
    serial_in_or_debug_irq_out <= tdi;
    repeat (5) @(posedge clk_in);
    tdo = serial_out_or_trace_bit0_in;
    test_clock_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    test_clock_out <= 1'b0;
  endtask : tck_cycle

  // Idle to shift, n bits lowest first, then update and back to idle
  task automatic access(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
    logic b;
    int i;
    dout = '0;
    if (ir) tck_cycle(1'b1, 1'b1, b);
    tck_cycle(1'b1, 1'b1, b);
    tck_cycle(1'b0, 1'b1, b);
    tck_cycle(1'b0, 1'b1, b);
    for (i = 0; i < n; i++) begin
      tck_cycle(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tck_cycle(1'b1, 1'b1, b);
    tck_cycle(1'b0, 1'b1, b);
  endtask : access
endmodule : debug_probe

//--- testbench/debug_scan_and_pc_trace_port_tb_top.sv
// Self-checking bench for the debug scan and trace port
`timescale 1ns/1ns
`include "debug_port_consts.svh"
module debug_scan_and_pc_trace_port_tb_top;
  import debug_port_pkg::*;
  // Arbitrary identification value
  localparam logic [31:0] IDC = 32'h5a3c96e1;
  logic clk_in, rst_n_in, test_reset_n_in, trace_valid_in, trace_ready_out;
  logic tck, tms, tdi, tdo, dbg_clk, trace_mode_out, tod;
  logic [2:0] upper;
  logic [8:0] status;
  trace_word_type trace_word_in;
  trace_word_type sent_q[$];
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  debug_port #(.IDCODE_VALUE(IDC), .FIFO_DEPTH(8)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .test_clock_in(tck),
    .test_mode_sel_in(tms), .test_reset_n_in(test_reset_n_in),
    .serial_in_or_debug_irq_in(tdi), .serial_out_or_trace_bit0_out(tdo),
    .trace_pc_upper_bits_out(upper), .trace_status_bus_out(status),
    .debug_clock_out(dbg_clk), .trace_word_in(trace_word_in),
    .trace_valid_in(trace_valid_in), .trace_ready_out(trace_ready_out),
    .trace_mode_out(trace_mode_out), .bus_timeout_disable_out(tod)
  );

  debug_probe u (
    .clk_in(clk_in), .test_clock_out(tck), .test_mode_sel_out(tms),
    .serial_in_or_debug_irq_out(tdi), .serial_out_or_trace_bit0_in(tdo),
    .trace_pc_upper_bits_in(upper), .trace_status_bus_in(status),
    .debug_clock_in(dbg_clk)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_vec(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_vec

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_clk

  function automatic trace_word_type mk(input int k);
    mk.status = 9'h101 + 9'(k);
    mk.pc = 32'h13579bdf ^ {8{4'(k)}};
  endfunction : mk

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check_bit(trace_mode_out, 1'b0);
    check_vec(32'(status), 32'(`STATUS_RESET));
    check_vec(32'(upper), 32'(`UPPER_RESET));
    check_bit(tdo, 1'b0);
    check_bit(tod, 1'b1);
    test_reset_n_in <= 1'b0;
    wait_clk(5);
    check_bit(tod, 1'b0);
    test_reset_n_in <= 1'b1;
    wait_clk(5);
    check_bit(tod, 1'b1);
  endtask : t_reset

  task automatic t_div;
    logic [8:0] s;
    int i;
    for (i = 0; i < 9; i++) begin
      @(negedge clk_in);
      s[i] = dbg_clk;
    end
    for (i = 0; i < 6; i++) begin
      check_bit(s[i], s[i+3]);
    end
    check_vec(32'($countones(s[2:0])), 32'h1);
    @(posedge clk_in);
  endtask : t_div

  task automatic t_scan;
    logic [31:0] d;
    u.access(1'b0, 32, 32'h0, d);
    check_vec(d, IDC);
    u.access(1'b1, 4, 32'(`IR_BYPASS), d);
    check_vec(32'(d[3:0]), 32'(`IR_CAPTURE_VALUE));
    u.access(1'b0, 8, 32'hb5, d);
    check_vec(32'(d[7:0]), 32'h6a);
  endtask : t_scan

  task automatic trace_on;
    logic [31:0] d;
    u.access(1'b1, 4, 32'(`IR_TRACE), d);
    u.access(1'b0, 1, 32'h1, d);
    check_bit(trace_mode_out, 1'b1);
  endtask : trace_on

  // Pushes up to n words; stops where the buffer refuses
  task automatic t_stream(input int n);
    trace_word_type w;
    int acc, i, j, k;
    sent_q.delete();
    u.cap_q.delete();
    u.cap_en_r = 1'b1;
    acc = 0;
    trace_word_in <= mk(0);
    trace_valid_in <= 1'b1;
    while (acc < n) begin
      @(negedge clk_in);
      if (trace_ready_out !== 1'b1) break;
      sent_q.push_back(mk(acc));
      acc++;
      @(posedge clk_in);
      trace_word_in <= mk(acc);
    end
    if (acc < n) @(posedge clk_in);
    trace_valid_in <= 1'b0;
    check_bit(n == 3 ? acc == 3 : acc >= 8 && acc < n, 1'b1);
    wait_clk(24 * acc + 40);
    u.cap_en_r = 1'b0;
    k = 0;
    while (k < u.cap_q.size() && u.cap_q[k][12:4] === 9'h0) k++;
    for (i = 0; i < acc; i++) begin
      w = sent_q[i];
      for (j = 0; j < 8; j++) begin
        check_vec(32'(u.cap_q[k]), 32'({j == 0 ? w.status : 9'h0, w.pc[4*j +: 4]}));
        k++;
      end
    end
  endtask : t_stream

  task automatic t_cancel;
    u.serial_in_or_debug_irq_out <= 1'b0;
    wait_clk(5);
    check_bit(trace_mode_out, 1'b0);
    u.serial_in_or_debug_irq_out <= 1'b1;
    wait_clk(3);
  endtask : t_cancel

  task automatic t_trst;
    logic [31:0] d;
    logic b;
    trace_on;
    test_reset_n_in <= 1'b0;
    #3;
    check_bit(trace_mode_out, 1'b0);
    check_vec(32'(status), 32'(`STATUS_RESET));
    @(posedge clk_in);
    test_reset_n_in <= 1'b1;
    wait_clk(4);
    u.tck_cycle(1'b0, 1'b1, b);
    u.access(1'b0, 32, 32'h0, d);
    check_vec(d, IDC);
  endtask : t_trst

  initial begin
    logic b;
    rst_n_in = 1'b0;
    test_reset_n_in = 1'b0;
    trace_valid_in = 1'b0;
    trace_word_in = '0;
    wait_clk(20);
    rst_n_in <= 1'b1;
    test_reset_n_in <= 1'b1;
    wait_clk(6);
    t_reset;
    t_div;
    u.tck_cycle(1'b0, 1'b1, b);
    t_scan;
    trace_on;
    t_stream(3);
    t_stream(12);
    t_cancel;
    t_trst;
    print_verdict;
  end
endmodule : debug_scan_and_pc_trace_port_tb_top
